/* File: logic/irs_params.svh */
// Constants for the I2C read sequencer: timing, field codes, frame positions
//
// Overview of operation
// - Format bit 1 combined read, 0 normal read
// - Start reads only on accepted send with read select
// - Controller drives clock from START to STOP
// - Combined: address, pointer bytes, then repeated START
// - Drive read address, then release data line
// - Acknowledge every received byte except the last
// - Last byte gets NACK, then STOP
// - Pointer one or two bytes, data one to four
// - Pointer field 0 one byte; length 01 two
// - Seven-bit normal read: address, then data only
// - Ten-bit normal read: repeated START, no pointer
// - Pointer-only write when alternate bit, length 10
// - Digital monitor: raw level versus driven level
// - Digital enable gates digital flag into alert
// - Filtered monitor: filtered level versus driven level
// - Filtered enable gates filtered flag into alert
// - Raw and filtered checks separate: a stuck-low input sets only its own flag
// - Send while busy rejected, flagged, transaction untouched
// - Missing ack flagged, transaction runs to STOP
`ifndef IRS_PARAMS_SVH
`define IRS_PARAMS_SVH

`define IRS_CLK_MHZ 25
`define IRS_QUARTER_NS 625
`define IRS_QUARTER_CYC ((`IRS_QUARTER_NS * `IRS_CLK_MHZ) / 1000)
`define IRS_QCNT_W 5
`define IRS_FIFO_DEPTH 8
`define IRS_BYTE_W 8
`define IRS_SEQ_LEN 5
`define IRS_ACK_BIT 4'h8
`define IRS_LAST_DATA_BIT 4'h7
`define IRS_Q_LOW0 2'h0
`define IRS_Q_HIGH1 2'h1
`define IRS_Q_HIGH2 2'h2
`define IRS_Q_LOW3 2'h3
`define IRS_TEN_BIT_HEAD 5'h1E
`define IRS_PTR_WRITE_LEN 2'h2
`define IRS_NO_RESTART 3'h7
`define IRS_RD_RESET 32'h0000_0000

`endif

/* File: logic/irs_pkg.sv */
// Types shared by the I2C read sequencer
`default_nettype none
package irs_pkg;
	typedef enum logic [2:0]
	{
		IRS_IDLE = 3'h0,
		IRS_START = 3'h1,
		IRS_TX = 3'h3,
		IRS_RSTART = 3'h2,
		IRS_RX = 3'h6,
		IRS_STOP = 3'h7
	} irs_state_t;
endpackage : irs_pkg
`default_nettype wire

/* File: logic/irs_read_sequencer.sv */
// I2C read sequencer with contention monitors and received-byte FIFO
`timescale 1ns/1ps
`default_nettype none
`include "irs_params.svh"

////////////////////////////////////////////////////////////////////////////////
module irs_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [0:DEPTH-1];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;

	assign in_ready = (count != (AW+1)'(DEPTH));
	assign out_valid = (count != '0);
	assign out_data = mem[rd_ptr];

	always_ff @(posedge core_clk)
	begin
		if (push)
			mem[wr_ptr] <= in_data;
	end

	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end
		else
		begin
			if (push)
				wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule : irs_fifo

////////////////////////////////////////////////////////////////////////////////
module irs_read_sequencer
	import irs_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic transaction_send_command,
	input wire logic read_write_select,
	input wire logic read_format_select,
	input wire logic ten_bit_address_select,
	input wire logic alternate_write_select,
	input wire logic pointer_length_field,
	input wire logic [1:0] data_length_field,
	input wire logic [9:0] target_address,
	input wire logic [15:0] pointer_bytes,
	input wire logic digital_contention_alert_enable,
	input wire logic filtered_contention_alert_enable,
	input wire logic status_clear,
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic scl_filtered_in,
	input wire logic sda_filtered_in,
	output logic scl_out,
	output logic scl_oe_n,
	output logic sda_out,
	output logic sda_oe_n,
	output logic busy,
	output logic request_rejected_flag,
	output logic address_nack_flag,
	output logic data_nack_flag,
	output logic digital_contention_flag,
	output logic filtered_contention_flag,
	output logic summary_bus_alert,
	output logic [31:0] read_data,
	output logic rx_valid,
	input wire logic rx_ready,
	output logic [7:0] rx_data
);
	// First address byte: plain 7-bit address or the 10-bit header
	function automatic logic [7:0] first_addr(input logic [9:0] a, input logic ten,
		input logic rd);
		first_addr = ten ? {`IRS_TEN_BIT_HEAD, a[9:8], rd} : {a[6:0], rd};
	endfunction : first_addr

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers: scl, sda, filtered scl, filtered sda
	logic [3:0] pin_meta;
	logic [3:0] pin_sync;
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			pin_meta <= 4'hF;
			pin_sync <= 4'hF;
		end
		else
		begin
			pin_meta <= {sda_filtered_in, scl_filtered_in, sda_in, scl_in};
			pin_sync <= pin_meta;
		end
	end
	wire scl_raw = pin_sync[0];
	wire sda_raw = pin_sync[1];
	wire scl_filt = pin_sync[2];
	wire sda_filt = pin_sync[3];

	////////////////////////////////////////////////////////////////////////////
	// Sequencer state
	irs_state_t state;
	irs_state_t next_state;
	logic [`IRS_QCNT_W-1:0] qcnt;
	logic [1:0] quarter;
	logic [3:0] bit_cnt;
	logic [2:0] byte_cnt;
	logic [7:0] seq [0:`IRS_SEQ_LEN-1];
	logic [`IRS_SEQ_LEN-1:0] addr_mask;
	logic [2:0] seq_len;
	logic [2:0] restart_at;
	logic [1:0] rx_last;
	logic read_mode;
	logic [7:0] rx_shift;

	// Command decode and byte list for the request on the ports
	logic [7:0] next_seq [0:`IRS_SEQ_LEN-1];
	logic [`IRS_SEQ_LEN-1:0] next_mask;
	logic [2:0] next_len;
	logic [2:0] next_restart;
	wire ptr_write = !read_write_select && alternate_write_select
		&& (data_length_field == `IRS_PTR_WRITE_LEN);
	wire cmd_ok = read_write_select || ptr_write;
	wire accept = transaction_send_command && !busy && cmd_ok;
	wire reject = transaction_send_command && busy;
	wire with_ptr = ptr_write || read_format_select;
	wire with_restart = read_write_select && (read_format_select || ten_bit_address_select);

	always_comb
	begin
		logic [2:0] k;
		k = 3'h0;
		for (int i = 0; i < `IRS_SEQ_LEN; i++)
			next_seq[i] = 8'h00;
		next_mask = '0;
		next_restart = `IRS_NO_RESTART;
		if (!read_write_select || with_restart)
		begin
			next_seq[k] = first_addr(target_address, ten_bit_address_select, 1'b0);
			next_mask[k] = 1'b1;
			k = k + 3'h1;
			if (ten_bit_address_select)
			begin
				next_seq[k] = target_address[7:0];
				next_mask[k] = 1'b1;
				k = k + 3'h1;
			end
			if (with_ptr)
			begin
				if (pointer_length_field)
				begin
					next_seq[k] = pointer_bytes[15:8];
					k = k + 3'h1;
				end
				next_seq[k] = pointer_bytes[7:0];
				k = k + 3'h1;
			end
		end
		if (read_write_select)
		begin
			if (with_restart)
				next_restart = k;
			next_seq[k] = first_addr(target_address, ten_bit_address_select, 1'b1);
			next_mask[k] = 1'b1;
			k = k + 3'h1;
		end
		next_len = k;
	end

	////////////////////////////////////////////////////////////////////////////
	// Quarter-bit timing; stalls with SCL low while the FIFO is full
	logic fifo_in_ready;
	wire rx_byte_done = (state == IRS_RX) && (bit_cnt == `IRS_LAST_DATA_BIT)
		&& (quarter == `IRS_Q_LOW3);
	wire stall = rx_byte_done && !fifo_in_ready;
	wire tick = (qcnt == `IRS_QCNT_W'(`IRS_QUARTER_CYC - 1)) && !stall;
	wire end_bit = tick && (quarter == `IRS_Q_LOW3);
	wire sample = tick && (quarter == `IRS_Q_HIGH1);
	wire push_byte = tick && rx_byte_done;
	wire last_tx = (byte_cnt == seq_len - 3'h1);
	wire last_rx = (byte_cnt[1:0] == rx_last);
	wire [7:0] tx_byte = seq[byte_cnt];

	always_comb
	begin
		next_state = state;
		case (state)
			IRS_IDLE:
				if (accept)
					next_state = IRS_START;
			IRS_START, IRS_RSTART:
				if (end_bit)
					next_state = IRS_TX;
			IRS_TX:
				if (end_bit && bit_cnt == `IRS_ACK_BIT)
				begin
					if (last_tx)
						next_state = read_mode ? IRS_RX : IRS_STOP;
					else if (byte_cnt + 3'h1 == restart_at)
						next_state = IRS_RSTART;
				end
			IRS_RX:
				if (end_bit && bit_cnt == `IRS_ACK_BIT && last_rx)
					next_state = IRS_STOP;
			IRS_STOP:
				if (end_bit)
					next_state = IRS_IDLE;
			default:
				next_state = IRS_IDLE;
		endcase
	end

	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state <= IRS_IDLE;
			qcnt <= '0;
			quarter <= `IRS_Q_LOW0;
		end
		else
		begin
			state <= next_state;
			if (state == IRS_IDLE || tick)
				qcnt <= '0;
			else if (!stall)
				qcnt <= qcnt + 1'b1;
			if (state == IRS_IDLE)
				quarter <= `IRS_Q_LOW0;
			else if (tick)
				quarter <= quarter + 2'h1;
		end
	end

	// Bit and byte counters, captured command
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			bit_cnt <= '0;
			byte_cnt <= '0;
			seq_len <= '0;
			restart_at <= `IRS_NO_RESTART;
			rx_last <= '0;
			read_mode <= 1'b0;
			addr_mask <= '0;
			rx_shift <= '0;
			for (int i = 0; i < `IRS_SEQ_LEN; i++)
				seq[i] <= 8'h00;
		end
		else
		begin
			if (accept)
			begin
				seq <= next_seq;
				addr_mask <= next_mask;
				seq_len <= next_len;
				restart_at <= next_restart;
				rx_last <= data_length_field;
				read_mode <= read_write_select;
				byte_cnt <= '0;
				bit_cnt <= '0;
			end
			else if (end_bit)
			begin
				if (state != IRS_TX && state != IRS_RX)
					bit_cnt <= '0;
				else if (bit_cnt == `IRS_ACK_BIT)
				begin
					bit_cnt <= '0;
					byte_cnt <= (state == IRS_TX && last_tx) ? 3'h0 : byte_cnt + 3'h1;
				end
				else
					bit_cnt <= bit_cnt + 4'h1;
			end
			if (sample && state == IRS_RX && bit_cnt != `IRS_ACK_BIT)
				rx_shift <= {rx_shift[6:0], sda_raw};
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Line drive per quarter
	logic next_scl;
	logic next_sda;
	logic next_sda_drv;
	wire scl_high = (quarter == `IRS_Q_HIGH1) || (quarter == `IRS_Q_HIGH2);
	always_comb
	begin
		next_scl = 1'b1;
		next_sda = 1'b1;
		next_sda_drv = 1'b1;
		case (state)
			IRS_IDLE:
				next_sda_drv = 1'b0;
			IRS_START, IRS_RSTART:
			begin
				next_scl = scl_high;
				next_sda = (quarter == `IRS_Q_LOW0) || (quarter == `IRS_Q_HIGH1);
			end
			IRS_TX:
			begin
				next_scl = scl_high;
				next_sda = tx_byte[3'h7 - bit_cnt[2:0]];
				next_sda_drv = (bit_cnt != `IRS_ACK_BIT);
			end
			IRS_RX:
			begin
				next_scl = scl_high;
				next_sda = last_rx;
				next_sda_drv = (bit_cnt == `IRS_ACK_BIT);
			end
			IRS_STOP:
			begin
				next_scl = (quarter != `IRS_Q_LOW0);
				next_sda = (quarter == `IRS_Q_HIGH2) || (quarter == `IRS_Q_LOW3);
			end
			default:
				next_sda_drv = 1'b0;
		endcase
	end

	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			scl_out <= 1'b1;
			scl_oe_n <= 1'b1;
			sda_out <= 1'b1;
			sda_oe_n <= 1'b1;
			busy <= 1'b0;
		end
		else
		begin
			scl_out <= next_scl;
			scl_oe_n <= (next_state == IRS_IDLE);
			sda_out <= next_sda;
			sda_oe_n <= !next_sda_drv;
			busy <= (next_state != IRS_IDLE);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Status flags; a new event wins over a clear in the same cycle
	wire ack_missing = sample && state == IRS_TX && bit_cnt == `IRS_ACK_BIT && sda_raw;
	wire eval = sample && !scl_oe_n;
	wire dig_err = eval && ((scl_raw != scl_out) || (!sda_oe_n && sda_raw != sda_out));
	wire filt_err = eval && ((scl_filt != scl_out) || (!sda_oe_n && sda_filt != sda_out));

	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			request_rejected_flag <= 1'b0;
			address_nack_flag <= 1'b0;
			data_nack_flag <= 1'b0;
			digital_contention_flag <= 1'b0;
			filtered_contention_flag <= 1'b0;
			summary_bus_alert <= 1'b0;
		end
		else
		begin
			request_rejected_flag <= reject || (request_rejected_flag && !status_clear);
			address_nack_flag <= (ack_missing && addr_mask[byte_cnt])
				|| (address_nack_flag && !status_clear);
			data_nack_flag <= (ack_missing && !addr_mask[byte_cnt])
				|| (data_nack_flag && !status_clear);
			digital_contention_flag <= dig_err
				|| (digital_contention_flag && !status_clear);
			filtered_contention_flag <= filt_err
				|| (filtered_contention_flag && !status_clear);
			summary_bus_alert <= request_rejected_flag
				|| (digital_contention_flag && digital_contention_alert_enable)
				|| (filtered_contention_flag && filtered_contention_alert_enable);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Received bytes: word image and stream FIFO
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
			read_data <= `IRS_RD_RESET;
		else if (push_byte)
			read_data[byte_cnt[1:0]*8 +: 8] <= rx_shift;
	end

	irs_fifo #(
		.WIDTH(`IRS_BYTE_W),
		.DEPTH(`IRS_FIFO_DEPTH)
	) u_fifo (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.in_valid(push_byte),
		.in_ready(fifo_in_ready),
		.in_data(rx_shift),
		.out_valid(rx_valid),
		.out_ready(rx_ready),
		.out_data(rx_data)
	);
endmodule : irs_read_sequencer
`default_nettype wire

/* File: testbench/irs_read_sequencer_chk.sv */
// Port checker for the I2C read sequencer
`timescale 1ns/1ps
`default_nettype none
module irs_chk (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic transaction_send_command,
	input wire logic read_write_select,
	input wire logic alternate_write_select,
	input wire logic [1:0] data_length_field,
	input wire logic digital_contention_alert_enable,
	input wire logic filtered_contention_alert_enable,
	input wire logic status_clear,
	input wire logic scl_oe_n,
	input wire logic sda_oe_n,
	input wire logic busy,
	input wire logic request_rejected_flag,
	input wire logic digital_contention_flag,
	input wire logic filtered_contention_flag,
	input wire logic summary_bus_alert,
	input wire logic rx_valid,
	input wire logic rx_ready
);
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (!reset_n);
	property p_start;
		$rose(busy) |-> $past(transaction_send_command && (read_write_select ||
			(alternate_write_select && data_length_field == 2'h2)));
	endproperty
	a_start: assert property (p_start) else $error("busy without accepted send");
	property p_scl_drv;
		busy |-> !scl_oe_n;
	endproperty
	a_scl_drv: assert property (p_scl_drv) else $error("clock not driven");
	property p_idle;
		!busy ##1 !busy |-> scl_oe_n && sda_oe_n;
	endproperty
	a_idle: assert property (p_idle) else $error("pins held while idle");
	property p_rej;
		transaction_send_command && busy |=> request_rejected_flag && busy;
	endproperty
	a_rej: assert property (p_rej) else $error("busy send not rejected");
	property p_dig;
		digital_contention_flag && digital_contention_alert_enable |=> summary_bus_alert;
	endproperty
	a_dig: assert property (p_dig) else $error("digital flag not in alert");
	property p_flt;
		filtered_contention_flag && filtered_contention_alert_enable |=> summary_bus_alert;
	endproperty
	a_flt: assert property (p_flt) else $error("filtered flag not in alert");
	property p_cause;
		summary_bus_alert |-> $past(request_rejected_flag ||
			(digital_contention_flag && digital_contention_alert_enable) ||
			(filtered_contention_flag && filtered_contention_alert_enable));
	endproperty
	a_cause: assert property (p_cause) else $error("alert without cause");
	property p_sticky;
		digital_contention_flag && !status_clear |=> digital_contention_flag;
	endproperty
	a_sticky: assert property (p_sticky) else $error("contention flag lost");
	c_run: cover property ($fell(busy));
	c_rej: cover property ($rose(request_rejected_flag));
	c_full: cover property (rx_valid && !rx_ready && busy);
endmodule : irs_chk
bind irs_read_sequencer irs_chk i_irs_chk (.*);
`default_nettype wire

/* File: testbench/irs_target.sv */
// Behavioural I2C target: acks written bytes, sends counting data bytes
`timescale 1ns/1ps
`default_nettype none
module irs_target (
	input wire logic scl,
	input wire logic sda,
	input wire logic ack_en,
	output logic low
);
	int n_start = 0;
	int n_wr = 0;
	int n_rd = 0;
	int bitn = 0;
	logic [7:0] sh = 8'h00;
	logic [7:0] tx = 8'hA5;
	logic rd = 1'b0;
	logic go = 1'b0;
	logic first = 1'b0;
	initial low = 1'b0;
	always @(negedge sda)
		if (scl === 1'b1)
		begin
			n_start++;
			bitn = -1;
			first = 1'b1;
			rd = 1'b0;
			low = 1'b0;
			tx = 8'hA5;
		end
	always @(posedge scl)
		sh = {sh[6:0], sda};
	always @(negedge scl)
	begin
		bitn++;
		if (bitn == 8)
		begin
			// Receiver acks; read phase leaves the slot to the controller
			if (rd)
				n_rd++;
			else
				n_wr++;
			go = first && !rd && ack_en && sh[0];
			first = 1'b0;
			low = !rd && ack_en;
		end
		else if (bitn == 9)
		begin
			bitn = 0;
			if (rd && sh[0])
				rd = 1'b0;
			else if (rd)
				tx = tx + 8'h11;
			if (go)
				rd = 1'b1;
			go = 1'b0;
			low = rd && !tx[7];
		end
		else
			low = rd && !tx[7 - bitn];
	end
endmodule : irs_target
`default_nettype wire

/* File: testbench/irs_read_sequencer_bench.sv */
// Self-checking bench for the I2C read sequencer
`timescale 1ns/1ps
`default_nettype none
module irs_read_sequencer_bench;
	logic core_clk, reset_n, transaction_send_command, read_write_select, read_format_select;
	logic ten_bit_address_select, alternate_write_select, pointer_length_field, status_clear;
	logic digital_contention_alert_enable, filtered_contention_alert_enable, rx_ready;
	logic [1:0] data_length_field;
	logic [9:0] target_address;
	logic [15:0] pointer_bytes;
	logic scl_out, scl_oe_n, sda_out, sda_oe_n, busy, request_rejected_flag, address_nack_flag;
	logic data_nack_flag, digital_contention_flag, filtered_contention_flag, summary_bus_alert;
	logic rx_valid, t_low, ack_en, stk_raw, stk_flt;
	logic [31:0] read_data;
	logic [7:0] rx_data;
	wire scl_in, sda_in, scl_filtered_in, sda_filtered_in, sda_bus;
	int miscompares = 0;
	int n_compared = 0;
	int s0, w0, r0, dur;
	// Open-drain data line with pull-up; stuck faults reach only the sequencer's sda inputs, not the target
	assign scl_in = scl_oe_n | scl_out;
	assign scl_filtered_in = scl_in;
	assign sda_bus = (sda_oe_n | sda_out) & ~t_low;
	assign sda_in = sda_bus & ~stk_raw;
	assign sda_filtered_in = sda_bus & ~stk_flt;
	irs_read_sequencer i_irs_read_sequencer (.*);
	irs_target i_irs_target (.scl(scl_in), .sda(sda_bus), .ack_en(ack_en), .low(t_low));
	////////////////////////////////////////
	task automatic stop_test();
		$display("compared %0d mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : stop_test
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		n_compared++;
		if (s !== e)
		begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic go(input logic f, t, p, input logic [1:0] l, input logic rw, alt);
		@(posedge core_clk);
		read_format_select <= f;
		ten_bit_address_select <= t;
		pointer_length_field <= p;
		data_length_field <= l;
		read_write_select <= rw;
		alternate_write_select <= alt;
		transaction_send_command <= 1'b1;
		@(posedge core_clk);
		transaction_send_command <= 1'b0;
	endtask : go
	task automatic idle();
		dur = 0;
		@(negedge core_clk);
		while (busy !== 1'b0 && dur < 9000)
		begin
			@(posedge core_clk);
			dur++;
		end
		chk("busy_end", 32'h0, {31'h0, busy});
	endtask : idle
	task automatic clr();
		@(posedge core_clk);
		status_clear <= 1'b1;
		@(posedge core_clk);
		status_clear <= 1'b0;
	endtask : clr
	task automatic snap();
		s0 = i_irs_target.n_start;
		w0 = i_irs_target.n_wr;
		r0 = i_irs_target.n_rd;
	endtask : snap
	task automatic cnt(input int es, ew, er);
		chk("starts", es, i_irs_target.n_start - s0);
		chk("bytes_out", ew, i_irs_target.n_wr - w0);
		chk("bytes_in", er, i_irs_target.n_rd - r0);
	endtask : cnt
	////////////////////////////////////////
	task automatic t_modes();
		logic [31:0] m;
		for (int i = 0; i < 4; i++)
		begin
			m = (i == 3) ? 32'hFFFF_FFFF : (32'h1 << (8 * (i + 1))) - 32'h1;
			snap();
			go(i[1], i[0], i[0], i[1:0], 1'b1, 1'b0);
			idle();
			cnt(1 + (i[1] | i[0]), 1 + 2 * i[1] + 2 * i[0], i + 1);
			chk("read_data", 32'hD8C7_B6A5 & m, read_data & m);
		end
		chk("nack_flags", 32'h0, {30'h0, address_nack_flag, data_nack_flag});
	endtask : t_modes
	task automatic t_write();
		go(1'b0, 1'b0, 1'b0, 2'h2, 1'b0, 1'b0);
		@(negedge core_clk);
		chk("busy_plain_write", 32'h0, {31'h0, busy});
		snap();
		go(1'b0, 1'b0, 1'b1, 2'h2, 1'b0, 1'b1);
		idle();
		cnt(1, 3, 0);
	endtask : t_write
	task automatic t_reject();
		snap();
		go(1'b0, 1'b0, 1'b0, 2'h1, 1'b1, 1'b0);
		repeat (200) @(posedge core_clk);
		go(1'b0, 1'b0, 1'b0, 2'h1, 1'b1, 1'b0);
		idle();
		cnt(1, 1, 2);
		chk("rejected", 32'h3, {30'h0, request_rejected_flag, summary_bus_alert});
		chk("read_data", 32'hB6A5, {16'h0, read_data[15:0]});
		clr();
	endtask : t_reject
	task automatic t_nack();
		ack_en <= 1'b0;
		go(1'b0, 1'b0, 1'b0, 2'h0, 1'b1, 1'b0);
		idle();
		chk("addr_nack", 32'h1, {31'h0, address_nack_flag});
		chk("ran_full", 32'h1, {31'h0, dur > 1100});
		clr();
		go(1'b0, 1'b0, 1'b0, 2'h2, 1'b0, 1'b1);
		idle();
		chk("ptr_nack", 32'h3, {30'h0, address_nack_flag, data_nack_flag});
		ack_en <= 1'b1;
		clr();
	endtask : t_nack
	task automatic t_cont();
		stk_flt <= 1'b1;
		go(1'b0, 1'b0, 1'b0, 2'h0, 1'b1, 1'b0);
		idle();
		chk("contention", 32'h1, {30'h0, digital_contention_flag, filtered_contention_flag});
		chk("alert_off", 32'h0, {31'h0, summary_bus_alert});
		filtered_contention_alert_enable <= 1'b1;
		repeat (3) @(posedge core_clk);
		chk("alert_on", 32'h1, {31'h0, summary_bus_alert});
		filtered_contention_alert_enable <= 1'b0;
		stk_raw <= 1'b1;
		clr();
		go(1'b0, 1'b0, 1'b0, 2'h0, 1'b1, 1'b0);
		idle();
		chk("contention", 32'h3, {30'h0, digital_contention_flag, filtered_contention_flag});
		chk("alert_off", 32'h0, {31'h0, summary_bus_alert});
		digital_contention_alert_enable <= 1'b1;
		repeat (3) @(posedge core_clk);
		chk("alert_on", 32'h1, {31'h0, summary_bus_alert});
		digital_contention_alert_enable <= 1'b0;
		stk_raw <= 1'b0;
		stk_flt <= 1'b0;
		clr();
	endtask : t_cont
	task automatic t_fifo();
		rx_ready <= 1'b0;
		repeat (2)
		begin
			go(1'b0, 1'b0, 1'b0, 2'h3, 1'b1, 1'b0);
			idle();
		end
		go(1'b0, 1'b0, 1'b0, 2'h0, 1'b1, 1'b0);
		repeat (3000) @(posedge core_clk);
		chk("stretch", 32'h1, {31'h0, busy});
		rx_ready <= 1'b1;
		for (int k = 0; k < 9; k++)
		begin
			dur = 0;
			do
			begin
				@(negedge core_clk);
				dur++;
			end while (rx_valid !== 1'b1 && dur < 4000);
			chk("rx_data", 8'hA5 + 8'h11 * k[1:0], {24'h0, rx_data});
			@(posedge core_clk);
		end
		idle();
		chk("rx_empty", 32'h0, {31'h0, rx_valid});
	endtask : t_fifo
	////////////////////////////////////////
	initial
	begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end
	initial
	begin
		repeat (60000) @(posedge core_clk);
		miscompares++;
		stop_test();
	end
	initial
	begin
		{reset_n, transaction_send_command, read_write_select, read_format_select} = 4'h0;
		{ten_bit_address_select, alternate_write_select, pointer_length_field} = 3'h0;
		{status_clear, digital_contention_alert_enable, filtered_contention_alert_enable} = 3'h0;
		{stk_raw, stk_flt, data_length_field} = 4'h0;
		rx_ready = 1'b1;
		ack_en = 1'b1;
		target_address = 10'h05A;
		pointer_bytes = 16'h1234;
		repeat (5) @(posedge core_clk);
		reset_n <= 1'b1;
		t_modes();
		t_write();
		t_reject();
		t_nack();
		t_cont();
		t_fifo();
		stop_test();
	end
endmodule : irs_read_sequencer_bench
`default_nettype wire
